// *** logic/pbsram_defs.svh ***
// constants for the pipelined burst sram cycle decode
`ifndef PBSRAM_DEFS_SVH
`define PBSRAM_DEFS_SVH
`define PBSRAM_ADDR_W 19
`define PBSRAM_LANES 4
`define PBSRAM_LANE_W 9
`define PBSRAM_BURST_W 2
`define PBSRAM_SLEEP_CYC 2
`define PBSRAM_ADDR_RST 19'h0_0000
`define PBSRAM_BURST_STEP 2'h1
`endif

// *** logic/pbsram_pkg.sv ***
// types for the pipelined burst sram cycle decode
`include "pbsram_defs.svh"
package pbsram_pkg;
  typedef enum logic [2:0] {
    PBSRAM_OP_IDLE,
    PBSRAM_OP_DESELECT,
    PBSRAM_OP_SLEEP,
    PBSRAM_OP_BEGIN,
    PBSRAM_OP_NEXT,
    PBSRAM_OP_SUSPEND
  } pbsram_op_t;

  typedef struct packed {
    logic primary_select_n;
    logic expansion_select_high;
    logic expansion_select_low_n;
    logic processor_address_strobe_n;
    logic controller_address_strobe_n;
    logic burst_advance_n;
  } pbsram_ctrl_t;

  typedef struct packed {
    logic global_write_n;
    logic byte_write_enable_n;
    logic [`PBSRAM_LANES-1:0] byte_lane_write_n;
  } pbsram_wr_t;
endpackage : pbsram_pkg

// *** logic/pbsram_cycle_decode.sv ***
// cycle decode and storage of a pipelined double-cycle-deselect burst sram
`timescale 1ns/1ps
`include "pbsram_defs.svh"
module pbsram_cycle_decode #(
  parameter int ADDR_W = `PBSRAM_ADDR_W,
  parameter int LANES = `PBSRAM_LANES,
  parameter int LANE_W = `PBSRAM_LANE_W
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // pins, synchronised here except output_enable_n
  input wire pbsram_pkg::pbsram_ctrl_t ctrl,
  input wire pbsram_pkg::pbsram_wr_t wr,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic burst_order,
  input wire logic sleep_request,
  input wire logic output_enable_n,
  // data bus, three signals per pin
  input wire logic [LANES*LANE_W-1:0] data_in,
  output logic [LANES*LANE_W-1:0] data_out,
  output logic [LANES*LANE_W-1:0] data_oe
);
  import pbsram_pkg::*;

  localparam int DW = LANES * LANE_W;
  localparam int DEPTH = 1 << ADDR_W;

  ////////////////////////////////////////////////////////////////////////
  // two-flop synchronisers for the pins; oe is left out, it must act
  // between edges, and a glitch on it only gates the drivers
  pbsram_ctrl_t ctrl_m, c;
  pbsram_wr_t wr_m, w;
  logic [ADDR_W-1:0] addr_m, a;
  logic order_m, order_s, sleep_m, sleep_s;
  logic [DW-1:0] din_m, din;

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      ctrl_m <= '1;
      c <= '1;
      wr_m <= '1;
      w <= '1;
      addr_m <= '0;
      a <= '0;
      order_m <= 1'b1;
      order_s <= 1'b1;
      sleep_m <= 1'b0;
      sleep_s <= 1'b0;
      din_m <= '0;
      din <= '0;
    end else begin
      ctrl_m <= ctrl;
      c <= ctrl_m;
      wr_m <= wr;
      w <= wr_m;
      addr_m <= addr;
      a <= addr_m;
      order_m <= burst_order;
      order_s <= order_m;
      sleep_m <= sleep_request;
      sleep_s <= sleep_m;
      din_m <= data_in;
      din <= din_m;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // decode helpers
  function automatic logic is_write(input pbsram_wr_t v);
    // any low lane with byte enable, or global write
    return !v.global_write_n ||
           (!v.byte_write_enable_n && !(&v.byte_lane_write_n));
  endfunction : is_write

  function automatic logic [LANES-1:0] lane_mask(input pbsram_wr_t v);
    if (!v.global_write_n) begin
      return '1;
    end else if (!v.byte_write_enable_n) begin
      return ~v.byte_lane_write_n;
    end else begin
      return '0;
    end
  endfunction : lane_mask

  function automatic logic [1:0] burst_next(input logic [1:0] cur,
                                           input logic [1:0] first,
                                           input logic inter);
    logic [1:0] cnt;
    cnt = (cur ^ first) + `PBSRAM_BURST_STEP;
    if (inter) begin
      return first ^ cnt;
    end else begin
      return cur + `PBSRAM_BURST_STEP;
    end
  endfunction : burst_next

  ////////////////////////////////////////////////////////////////////////
  // sleep entry and exit take two clocks
  logic [1:0] sleep_cnt;
  logic asleep;

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      sleep_cnt <= '0;
      asleep <= 1'b0;
    end else if (sleep_s != asleep) begin
      if (sleep_cnt == 2'(`PBSRAM_SLEEP_CYC - 1)) begin
        asleep <= sleep_s;
        sleep_cnt <= '0;
      end else begin
        sleep_cnt <= sleep_cnt + 2'h1;
      end
    end else begin
      sleep_cnt <= '0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // cycle classification
  logic sel_ok, wr_now;
  pbsram_op_t op;

  always_comb begin
    sel_ok = c.expansion_select_high && !c.expansion_select_low_n;
    wr_now = is_write(w);
    if (asleep || sleep_s) begin
      op = PBSRAM_OP_SLEEP;
    end else if (!c.primary_select_n && !c.processor_address_strobe_n) begin
      op = sel_ok ? PBSRAM_OP_BEGIN : PBSRAM_OP_DESELECT;
    end else if (!c.controller_address_strobe_n) begin
      op = (sel_ok && !c.primary_select_n) ? PBSRAM_OP_BEGIN
                                           : PBSRAM_OP_DESELECT;
    end else if (!c.burst_advance_n) begin
      op = PBSRAM_OP_NEXT;
    end else begin
      op = PBSRAM_OP_SUSPEND;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // address register and burst counter
  logic [ADDR_W-1:0] cur_addr;
  logic [1:0] first_lo;
  logic active;

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      cur_addr <= `PBSRAM_ADDR_RST;
      first_lo <= '0;
      active <= 1'b0;
    end else begin
      case (op)
        PBSRAM_OP_BEGIN: begin
          cur_addr <= a;
          first_lo <= a[1:0];
          active <= 1'b1;
        end
        PBSRAM_OP_NEXT: begin
          cur_addr[1:0] <= burst_next(cur_addr[1:0], first_lo,
                                      order_s);
        end
        PBSRAM_OP_DESELECT, PBSRAM_OP_SLEEP: begin
          active <= 1'b0;
        end
        default: begin
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // storage array and byte-lane writes
  logic [DW-1:0] mem [DEPTH];
  logic [ADDR_W-1:0] wr_addr;
  logic do_write;
  logic [LANES-1:0] wr_lanes;

  always_comb begin
    wr_addr = cur_addr;
    do_write = 1'b0;
    wr_lanes = lane_mask(w);
    if (op == PBSRAM_OP_BEGIN) begin
      // both strobes read the pin address; a processor strobe never writes
      wr_addr = a;
      do_write = c.processor_address_strobe_n && wr_now;
    end else if (active && (op == PBSRAM_OP_NEXT ||
                            op == PBSRAM_OP_SUSPEND)) begin
      // the clock after a processor-strobe address takes writes
      if (op == PBSRAM_OP_NEXT) begin
        wr_addr[1:0] = burst_next(cur_addr[1:0], first_lo, order_s);
      end
      do_write = wr_now;
    end
  end

  always_ff @(posedge core_clk) begin
    if (do_write) begin
      for (int i = 0; i < LANES; i++) begin
        if (wr_lanes[i]) begin
          mem[wr_addr][i*LANE_W +: LANE_W] <=
            din[i*LANE_W +: LANE_W];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // pipelined read and double-cycle deselect
  logic rd_valid, drive_en;
  logic [DW-1:0] rd_data;

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      rd_valid <= 1'b0;
      rd_data <= '0;
    end else begin
      rd_valid <= !do_write && (op == PBSRAM_OP_BEGIN ||
                  (active && op != PBSRAM_OP_DESELECT &&
                   op != PBSRAM_OP_SLEEP));
      rd_data <= mem[wr_addr];
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      data_out <= '0;
      drive_en <= 1'b0;
    end else begin
      data_out <= rd_data;
      // output stage lags the read by a clock, so deselect costs one more
      drive_en <= rd_valid && !do_write && !asleep;
    end
  end

  // oe gates the drivers directly; it is never held in a flop
  always_comb begin
    data_oe = {DW{drive_en && !output_enable_n}};
  end

  ////////////////////////////////////////////////////////////////////////
  // checks
  sequence s_deselect;
    op == PBSRAM_OP_DESELECT && rd_valid;
  endsequence

  a_write_tristate: assert property (@(posedge core_clk) disable iff (!resetn)
    do_write |=> data_oe == '0) else $error("outputs driven in write");
  a_sleep_quiet: assert property (@(posedge core_clk) disable iff (!resetn)
    asleep |=> data_oe == '0) else $error("outputs driven asleep");
  a_oe_high_off: assert property (@(posedge core_clk) disable iff (!resetn)
    output_enable_n |-> data_oe == '0)
    else $error("oe high yet driving");
  a_proc_no_write: assert property (@(posedge core_clk) disable iff (!resetn)
    (op == PBSRAM_OP_BEGIN && !c.processor_address_strobe_n) |-> !do_write)
    else $error("write on processor strobe cycle");
  a_ctrl_write: assert property (@(posedge core_clk) disable iff (!resetn)
    (op == PBSRAM_OP_BEGIN && c.processor_address_strobe_n && wr_now)
    |-> do_write && wr_addr == a) else $error("missed begin write");
  a_suspend_hold: assert property (@(posedge core_clk) disable iff (!resetn)
    op == PBSRAM_OP_SUSPEND |=> $stable(cur_addr))
    else $error("address moved on suspend");
  a_next_upper: assert property (@(posedge core_clk) disable iff (!resetn)
    op == PBSRAM_OP_NEXT |=> cur_addr[ADDR_W-1:2] == $past(cur_addr[ADDR_W-1:2])
    && cur_addr[1:0] != $past(cur_addr[1:0]))
    else $error("burst step wrong");
  a_deselect_hold: assert property (@(posedge core_clk) disable iff (!resetn)
    s_deselect |=> drive_en ##1 !drive_en)
    else $error("deselect pipeline wrong");
  a_begin_load: assert property (@(posedge core_clk) disable iff (!resetn)
    op == PBSRAM_OP_BEGIN |=> cur_addr == $past(a))
    else $error("begin address not loaded");
  a_global_lanes: assert property (@(posedge core_clk) disable iff (!resetn)
    (do_write && !w.global_write_n) |-> wr_lanes == '1)
    else $error("global write missed a lane");
  a_sleep_enter: assert property (@(posedge core_clk) disable iff (!resetn)
    $rose(sleep_s) ##1 sleep_s |=> asleep)
    else $error("sleep entry timing");
  a_deselect_op: assert property (@(posedge core_clk) disable iff (!resetn)
    (!c.controller_address_strobe_n && c.primary_select_n && !asleep
     && !sleep_s) |-> op == PBSRAM_OP_DESELECT)
    else $error("deselect not decoded");
endmodule : pbsram_cycle_decode

// *** tb/pbsram_bus_master_model.sv ***
// bus master model driving the burst sram cycle decode
`timescale 1ns/1ps
module pbsram_bus_master_model (
  // clock
  input wire logic core_clk,
  // pins toward the sram
  output pbsram_pkg::pbsram_ctrl_t ctrl,
  output pbsram_pkg::pbsram_wr_t wr,
  output logic [18:0] addr,
  output logic burst_order,
  output logic sleep_request,
  output logic output_enable_n,
  output logic [35:0] data_in
);
  import pbsram_pkg::*;
  logic oe_rd_n = 1'b0;
  // set only by a scenario that leaves the enable low on writes
  logic rude = 1'b0;
  initial begin
    ctrl = pbsram_ctrl_t'(6'h35);
    wr = pbsram_wr_t'(6'h3f);
    addr = '0;
    burst_order = 1'b1;
    sleep_request = 1'b0;
    output_enable_n = 1'b1;
    data_in = '0;
  end
  task automatic cyc(input logic [5:0] c, input logic [5:0] w,
                     input logic [18:0] a, input logic [35:0] d);
    logic wrt;
    wrt = !w[5] || (!w[4] && (w[3:0] != 4'hf));
    @(posedge core_clk);
    ctrl <= pbsram_ctrl_t'(c);
    wr <= pbsram_wr_t'(w);
    addr <= a;
    // released bus shows the inverse, never a stale copy
    data_in <= wrt ? d : ~data_in;
    output_enable_n <= (wrt && !rude) ? 1'b1 : oe_rd_n;
  endtask : cyc
  task automatic set_pins(input logic oe_n, input logic slp,
                          input logic ord);
    @(posedge core_clk);
    // park the controls so the last cycle is not decoded again
    ctrl <= pbsram_ctrl_t'(6'h35);
    wr <= pbsram_wr_t'(6'h3f);
    output_enable_n <= oe_n;
    sleep_request <= slp;
    burst_order <= ord;
    oe_rd_n = oe_n;
  endtask : set_pins
endmodule : pbsram_bus_master_model

// *** tb/pbsram_cycle_decode_tb_top.sv ***
// self-checking bench for the burst sram cycle decode
`timescale 1ns/1ps
`include "pbsram_defs.svh"
module pbsram_cycle_decode_tb_top;
  import pbsram_pkg::*;
  localparam int DW = `PBSRAM_LANES * `PBSRAM_LANE_W;
  localparam logic [5:0] C_DES = 6'h35;
  localparam logic [5:0] C_DESX = 6'h05;
  localparam logic [5:0] C_CONTROLLER_ADDRESS_STROBE_N = 6'h15;
  localparam logic [5:0] C_PROCESSOR_ADDRESS_STROBE_N = 6'h13;
  localparam logic [5:0] C_NEXT = 6'h32;
  localparam logic [5:0] C_SUSP = 6'h33;
  localparam logic [5:0] W_RD = 6'h3f;
  localparam logic [5:0] W_ALL = 6'h1f;
  localparam logic [5:0] W_BRD = 6'h2f;
  localparam logic [DW-1:0] D_A = 36'h1_2345_6789;
  localparam logic [DW-1:0] D_B = 36'hf_edcb_a987;
  localparam logic [DW-1:0] D_C = 36'h5_a5a5_a5a5;
  localparam logic [DW-1:0] LANE_MASK = 36'h0_07fc_01ff;
  logic core_clk = 1'b0;
  logic resetn = 1'b0;
  pbsram_ctrl_t ctrl;
  pbsram_wr_t wr;
  logic [18:0] addr;
  logic burst_order;
  logic sleep_request;
  logic output_enable_n;
  logic [DW-1:0] data_in;
  logic [DW-1:0] data_out;
  logic [DW-1:0] data_oe;
  logic [DW-1:0] rd_q[$];
  int errors = 0;
  int checks = 0;
  always #4 core_clk = ~core_clk;
  // away from the edge, so the registered outputs have settled
  always @(negedge core_clk) begin
    if (data_oe === '1) rd_q.push_back(data_out);
  end
  pbsram_cycle_decode dut_u (.core_clk(core_clk), .resetn(resetn),
    .ctrl(ctrl), .wr(wr), .addr(addr), .burst_order(burst_order),
    .sleep_request(sleep_request), .output_enable_n(output_enable_n),
    .data_in(data_in), .data_out(data_out), .data_oe(data_oe));
  pbsram_bus_master_model m_u (.core_clk(core_clk), .ctrl(ctrl),
    .wr(wr), .addr(addr), .burst_order(burst_order),
    .sleep_request(sleep_request), .output_enable_n(output_enable_n),
    .data_in(data_in));
  ////////////////////////////////////////////////////////////////////
  task automatic check(input logic [DW-1:0] seen,
                       input logic [DW-1:0] exp, input string msg);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected at %0t: %s", $time, msg);
    end
  endtask : check
  task automatic summarize();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : summarize
  task automatic idle(input int n);
    repeat (n) m_u.cyc(C_DES, W_RD, '0, '0);
  endtask : idle
  ////////////////////////////////////////////////////////////////////
  task automatic t_write_read();
    rd_q.delete();
    m_u.rude = 1'b1;
    m_u.cyc(C_CONTROLLER_ADDRESS_STROBE_N, W_ALL, 19'h0_0100, D_A);
    m_u.cyc(C_CONTROLLER_ADDRESS_STROBE_N, 6'h20, 19'h0_0101, D_B);
    m_u.cyc(C_CONTROLLER_ADDRESS_STROBE_N, W_BRD, 19'h0_0100, D_C);
    m_u.cyc(C_PROCESSOR_ADDRESS_STROBE_N, W_ALL, 19'h0_0101, D_C);
    idle(8);
    m_u.rude = 1'b0;
    check(DW'(rd_q.size()), DW'(2), "read count");
    check(rd_q[0], D_A, "global write");
    check(rd_q[1], D_B, "strobe read");
    $display("done write_read");
  endtask : t_write_read
  task automatic t_bytes();
    rd_q.delete();
    m_u.cyc(C_CONTROLLER_ADDRESS_STROBE_N, W_ALL, 19'h0_0200, D_A);
    m_u.cyc(C_PROCESSOR_ADDRESS_STROBE_N, W_RD, 19'h0_0200, D_C);
    m_u.cyc(C_SUSP, 6'h2a, '0, D_B);
    m_u.cyc(C_CONTROLLER_ADDRESS_STROBE_N, W_RD, 19'h0_0200, '0);
    idle(8);
    check(DW'(rd_q.size()), DW'(1), "write masks read");
    check(rd_q[$], (D_B & LANE_MASK) | (D_A & ~LANE_MASK), "lanes");
    $display("done bytes");
  endtask : t_bytes
  task automatic t_burst();
    logic [DW-1:0] exp[5];
    exp = '{D_C, ~D_A, ~D_A, ~D_B, D_A};
    m_u.set_pins(1'b0, 1'b0, 1'b0);
    idle(3);
    m_u.cyc(C_CONTROLLER_ADDRESS_STROBE_N, W_ALL, 19'h0_0041, D_A);
    m_u.cyc(C_NEXT, W_ALL, '0, D_B);
    m_u.cyc(C_SUSP, W_ALL, '0, D_C);
    m_u.cyc(C_NEXT, W_ALL, '0, ~D_A);
    m_u.cyc(C_NEXT, W_ALL, '0, ~D_B);
    m_u.set_pins(1'b0, 1'b0, 1'b1);
    idle(3);
    rd_q.delete();
    m_u.cyc(C_CONTROLLER_ADDRESS_STROBE_N, W_RD, 19'h0_0042, '0);
    m_u.cyc(C_NEXT, W_RD, '0, '0);
    m_u.cyc(C_SUSP, W_RD, '0, '0);
    m_u.cyc(C_NEXT, W_RD, '0, '0);
    m_u.cyc(C_NEXT, W_RD, '0, '0);
    idle(8);
    check(DW'(rd_q.size()), DW'(5), "burst count");
    foreach (exp[i]) check(rd_q[i], exp[i], "burst data");
    $display("done burst");
  endtask : t_burst
  task automatic t_oe();
    rd_q.delete();
    m_u.set_pins(1'b1, 1'b0, 1'b1);
    m_u.cyc(C_CONTROLLER_ADDRESS_STROBE_N, W_RD, 19'h0_0100, '0);
    idle(8);
    check(DW'(rd_q.size()), '0, "enable high");
    m_u.set_pins(1'b0, 1'b0, 1'b1);
    m_u.cyc(C_CONTROLLER_ADDRESS_STROBE_N, W_RD, 19'h0_0100, '0);
    repeat (12) begin
      m_u.cyc(C_SUSP, W_RD, '0, '0);
      #1;
      if (data_oe === '1) break;
    end
    if (data_oe !== '1) begin
      errors++;
      summarize();
    end
    m_u.set_pins(1'b1, 1'b0, 1'b1);
    #1;
    check(data_oe, '0, "enable without clock");
    idle(4);
    $display("done oe");
  endtask : t_oe
  task automatic t_deselect();
    m_u.set_pins(1'b0, 1'b0, 1'b1);
    rd_q.delete();
    m_u.cyc(C_CONTROLLER_ADDRESS_STROBE_N, W_RD, 19'h0_0100, '0);
    repeat (8) m_u.cyc(C_DESX, W_RD, '0, '0);
    check(DW'(rd_q.size()), DW'(1), "deselect hold");
    check(rd_q[0], D_A, "deselect data");
    $display("done deselect");
  endtask : t_deselect
  task automatic t_sleep();
    rd_q.delete();
    m_u.set_pins(1'b0, 1'b1, 1'b1);
    idle(3);
    m_u.cyc(C_CONTROLLER_ADDRESS_STROBE_N, W_ALL, 19'h0_0100, D_C);
    m_u.cyc(C_CONTROLLER_ADDRESS_STROBE_N, W_RD, 19'h0_0100, '0);
    idle(8);
    check(DW'(rd_q.size()), '0, "asleep");
    m_u.set_pins(1'b0, 1'b0, 1'b1);
    idle(3);
    m_u.cyc(C_CONTROLLER_ADDRESS_STROBE_N, W_RD, 19'h0_0100, '0);
    idle(8);
    check(rd_q[0], D_A, "sleep write");
    $display("done sleep");
  endtask : t_sleep
  ////////////////////////////////////////////////////////////////////
  initial begin
    repeat (6) @(posedge core_clk);
    resetn <= 1'b1;
    t_write_read();
    t_bytes();
    t_burst();
    t_oe();
    t_deselect();
    t_sleep();
    summarize();
  end
endmodule : pbsram_cycle_decode_tb_top
